// ===== rtl/fcpd_regs.svh
/*
  Constants for the command parameter decoder: reset defaults, sizing
  figures and the interval unit. Assumes inclusion by bare name.
*/
`ifndef FCPD_REGS_SVH
`define FCPD_REGS_SVH

// ------------------------------------------------------------
// Reset defaults and the fixed gap 2 default
// ------------------------------------------------------------
`define FCPD_QDIS_RST 1'b1
`define FCPD_QTHR_RST 4'h0
`define FCPD_PRECOMP_START_CYLINDER_RST 8'h00
`define FCPD_SETTLE_RST 8'h01
`define FCPD_RELEASE_RST 8'h01
`define FCPD_GAP2_DFLT 8'h16

// ------------------------------------------------------------
// Sector size figures
// ------------------------------------------------------------
`define FCPD_BASE_SECT 15'h0080
`define FCPD_MAX_CODE 8'h07

// ------------------------------------------------------------
// Interval unit: one programmed step in cycles (250 MHz)
// ------------------------------------------------------------
`define FCPD_STEP_NS 1000
`define FCPD_CLK_NS 4
`define FCPD_STEP_CYC ((`FCPD_STEP_NS + `FCPD_CLK_NS - 1) / `FCPD_CLK_NS)

`endif

// ===== rtl/fcpd_pkg.sv
/*
  Types shared by the command parameter decoder.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package fcpd_pkg;

  // ------------------------------------------------------------
  // Latched command parameters
  // ------------------------------------------------------------
  typedef struct packed {
    logic two_side_track_join;
    logic mfm_sel;
    logic head_side_select;
    logic [7:0] size_code;
    logic [7:0] last_sector_of_track;
    logic [7:0] intersector_spacing_length;
    logic [7:0] id_data_spacing;
    logic [7:0] short_sector_byte_count;
  } fcpd_cmd_s;

  // Head timer states, Gray along idle->settle->ready->release
  typedef enum logic [1:0] {
    FCPD_IDLE = 2'b00,
    FCPD_SETTLE = 2'b01,
    FCPD_READY = 2'b11,
    FCPD_RELEASE = 2'b10
  } fcpd_head_e;

endpackage : fcpd_pkg

// ===== rtl/fcpd_head_if.sv
/*
  Interface between the decoder and its head timer.
  Assumes one clock domain.
*/
`timescale 1ns/1ps
interface fcpd_head_if;
  logic xfer_req;
  logic xfer_done;
  logic [7:0] settle_steps;
  logic [7:0] release_steps;
  logic head_loaded;
  logic head_ready;
  modport ctrl (output xfer_req, xfer_done, settle_steps, release_steps,
                input head_loaded, head_ready);
  modport timer (input xfer_req, xfer_done, settle_steps, release_steps,
                 output head_loaded, head_ready);
endinterface : fcpd_head_if

// ===== rtl/fcpd_head_timer.sv
/*
  Head load/settle and release timer.
  Assumes steps are counted in units of FCPD_STEP_CYC cycles.
*/
`timescale 1ns/1ps
`include "fcpd_regs.svh"
module fcpd_head_timer
  import fcpd_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  fcpd_head_if.timer hif
);

  localparam logic [15:0] STEP_CYC = 16'(`FCPD_STEP_CYC);

  fcpd_head_e st_q, st_d;
  logic [15:0] pre_q;
  logic [7:0] steps_q;
  wire tick = (pre_q == STEP_CYC - 16'h0001);
  wire count_done = tick && (steps_q == 8'h00);

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      FCPD_IDLE: if (hif.xfer_req) st_d = FCPD_SETTLE;
      // Settle always runs out; a command that ended meanwhile goes to release
      FCPD_SETTLE: if (count_done) st_d = hif.xfer_req ? FCPD_READY : FCPD_RELEASE; // [RQ8]
      FCPD_READY: if (hif.xfer_done) st_d = FCPD_RELEASE;
      FCPD_RELEASE: begin
        if (hif.xfer_req) st_d = FCPD_READY; // Head still down, no settle
        else if (count_done) st_d = FCPD_IDLE; // [RQ9]
      end
    endcase
  end

  // Prescaler restarts on each state change so intervals are whole
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_q <= FCPD_IDLE;
      pre_q <= 16'h0000;
      steps_q <= 8'h00;
    end else begin
      st_q <= st_d;
      if (st_d != st_q) begin
        pre_q <= 16'h0000;
        steps_q <= (st_d == FCPD_SETTLE) ? hif.settle_steps : hif.release_steps;
      end else if (tick) begin
        pre_q <= 16'h0000;
        if (steps_q != 8'h00) steps_q <= steps_q - 8'h01;
      end else begin
        pre_q <= pre_q + 16'h0001;
      end
    end
  end

  assign hif.head_loaded = (st_q != FCPD_IDLE);
  assign hif.head_ready = (st_q == FCPD_READY);

  a_settle_wait: assert property (@(posedge mclk) disable iff (!rst_n) // [RQ8]
    st_q == FCPD_IDLE && hif.xfer_req |=> !hif.head_ready[*2])
    else $error("head ready without settle");

endmodule : fcpd_head_timer

// ===== rtl/fcpd_param_decode.sv
/*
  Floppy command-phase parameter decoder: latches parameters, applies
  configure settings, sequences sectors and times the head.
  Assumes a sequencer that presents command bytes and per-sector strobes.
*/
// Operation
// [RQ1] Count flag makes byte count the sectors
// [RQ2] Queue enabled when disable bit is zero
// [RQ3] Auto-seek seeks before cylinder transfers
// [RQ4] Stop sequencing at last sector of track
// [RQ5] ID-data spacing applies only in perpendicular
// [RQ6] Inter-sector spacing sets third gap length
// [RQ7] Head side selects head zero or one
// [RQ8] Wait settle interval after head load
// [RQ9] Release head after release interval
// [RQ10] Retain flag guards settings on soft reset
// [RQ11] Density selector one means MFM
// [RQ12] Track join spans both heads
// [RQ13] Continue on head one after head zero
// [RQ14] Code zero uses byte count length
// [RQ15] Size is 128 shifted by code
// [RQ16] Host avoids unsupported size combinations
// [RQ17] Short sector pads zeros, CRC whole
// [RQ18] Parameters held through execution
`timescale 1ns/1ps
`include "fcpd_regs.svh"
module fcpd_param_decode
  import fcpd_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic soft_reset,
  input wire logic cfg_load,
  input wire logic cfg_queue_disable_bit,
  input wire logic cfg_auto_seek_before_transfer,
  input wire logic [3:0] cfg_queue_threshold,
  input wire logic [7:0] cfg_precomp_start_cylinder,
  input wire logic lock_load,
  input wire logic lock_value,
  input wire logic perp_mode,
  input wire logic spec_load,
  input wire logic [7:0] spec_head_settle_interval,
  input wire logic [7:0] spec_head_release_interval,
  input wire logic cmd_start,
  input wire logic cmd_is_verify,
  input wire logic cmd_has_cyl,
  input wire logic cmd_verify_by_count_flag,
  input wire fcpd_cmd_s cmd_in,
  input wire logic [7:0] cmd_first_sector,
  input wire logic sector_done,
  input wire logic exec_end,
  input wire logic seek_done,
  output logic queue_enable,
  output logic [3:0] queue_threshold,
  output logic [7:0] precomp_start_cylinder,
  output logic settings_retain,
  output logic seek_req,
  output logic xfer_go,
  output logic mfm_mode,
  output logic head_out,
  output logic [7:0] sector_num,
  output logic track_end,
  output logic [7:0] gap2_len,
  output logic [7:0] gap3_len,
  output logic [14:0] phys_sector_bytes,
  output logic [14:0] host_bytes,
  output logic [7:0] verify_sectors,
  output logic verify_count_mode,
  output logic head_loaded,
  output logic [7:0] gap2_default
);

  // ------------------------------------------------------------
  // Configure settings
  // ------------------------------------------------------------
  logic qdis_q, eis_q, lock_q;
  logic [3:0] qthr_q;
  logic [7:0] precomp_start_cylinder_q;
  logic [7:0] hst_q, hrt_q;
  wire soft_clear = soft_reset && !lock_q; // [RQ10]

  // Soft reset loses to lock and to cfg_load; load wins over soft clear
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      qdis_q <= `FCPD_QDIS_RST;
      qthr_q <= `FCPD_QTHR_RST;
      precomp_start_cylinder_q <= `FCPD_PRECOMP_START_CYLINDER_RST;
      eis_q <= 1'b0;
      lock_q <= 1'b0;
      hst_q <= `FCPD_SETTLE_RST;
      hrt_q <= `FCPD_RELEASE_RST;
    end else begin
      if (cfg_load) begin
        qdis_q <= cfg_queue_disable_bit;
        qthr_q <= cfg_queue_threshold;
        precomp_start_cylinder_q <= cfg_precomp_start_cylinder;
        eis_q <= cfg_auto_seek_before_transfer;
      end else if (soft_clear) begin
        qdis_q <= `FCPD_QDIS_RST; // [RQ10]
        qthr_q <= `FCPD_QTHR_RST;
        precomp_start_cylinder_q <= `FCPD_PRECOMP_START_CYLINDER_RST;
      end
      if (lock_load) lock_q <= lock_value;
      if (spec_load) begin
        hst_q <= spec_head_settle_interval;
        hrt_q <= spec_head_release_interval;
      end
    end
  end

  assign queue_enable = !qdis_q; // [RQ2]
  assign queue_threshold = qthr_q;
  assign precomp_start_cylinder = precomp_start_cylinder_q;
  assign settings_retain = lock_q;
  assign gap2_default = `FCPD_GAP2_DFLT;

  // ------------------------------------------------------------
  // Command latch and sequencing
  // ------------------------------------------------------------
  fcpd_cmd_s cmd_q;
  logic busy_q, ec_q, vfy_q, seek_q, head_q;
  logic [7:0] sect_q;
  logic [7:0] sect_cnt_q;

  wire last_sect = (sect_q == cmd_q.last_sector_of_track); // [RQ4]
  wire can_switch = cmd_q.two_side_track_join && !head_q; // [RQ12]
  wire vfy_cnt_end = ec_q && vfy_q && (sect_cnt_q + 8'h01 == cmd_q.short_sector_byte_count);
  wire ends_now = busy_q && sector_done && ((last_sect && !can_switch) || vfy_cnt_end);

  // Parameters captured at start and held until execution ends
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cmd_q <= '0;
      busy_q <= 1'b0;
      ec_q <= 1'b0;
      vfy_q <= 1'b0;
      seek_q <= 1'b0;
      head_q <= 1'b0;
      sect_q <= 8'h00;
      sect_cnt_q <= 8'h00;
      track_end <= 1'b0;
    end else begin
      track_end <= 1'b0;
      if (cmd_start && !busy_q) begin
        cmd_q <= cmd_in; // [RQ18]
        busy_q <= 1'b1;
        ec_q <= cmd_verify_by_count_flag;
        vfy_q <= cmd_is_verify;
        seek_q <= eis_q && cmd_has_cyl; // [RQ3]
        head_q <= cmd_in.two_side_track_join ? 1'b0 : cmd_in.head_side_select; // [RQ7]
        sect_q <= cmd_first_sector;
        sect_cnt_q <= 8'h00;
      end else if (busy_q) begin
        if (seek_done) seek_q <= 1'b0;
        if (sector_done) begin
          sect_cnt_q <= sect_cnt_q + 8'h01;
          if (ends_now) begin
            track_end <= 1'b1;
          end else if (last_sect) begin
            head_q <= 1'b1; // [RQ13]
            sect_q <= 8'h01;
          end else begin
            sect_q <= sect_q + 8'h01;
          end
        end
        if (exec_end) busy_q <= 1'b0;
      end
    end
  end

  assign seek_req = busy_q && seek_q; // [RQ3]
  assign mfm_mode = cmd_q.mfm_sel; // [RQ11]
  assign head_out = head_q;
  assign sector_num = sect_q;
  assign gap2_len = perp_mode ? cmd_q.id_data_spacing : gap2_default; // [RQ5]
  assign gap3_len = cmd_q.intersector_spacing_length; // [RQ6]
  assign verify_count_mode = ec_q && vfy_q; // [RQ1]
  assign verify_sectors = cmd_q.short_sector_byte_count; // [RQ1]

  // ------------------------------------------------------------
  // Sector sizing; codes above the maximum clamp (host must avoid)
  // ------------------------------------------------------------
  wire [2:0] code_eff = (cmd_q.size_code > `FCPD_MAX_CODE) ? 3'h7 : cmd_q.size_code[2:0];
  assign phys_sector_bytes = `FCPD_BASE_SECT << code_eff; // [RQ15]
  // Code zero outside verify-count mode passes only counted bytes; rest padded zero, CRC full
  assign host_bytes = (cmd_q.size_code == 8'h00 && !verify_count_mode) ?
    {7'h00, cmd_q.short_sector_byte_count} : phys_sector_bytes; // [RQ14] [RQ17]

  // ------------------------------------------------------------
  // Head timer
  // ------------------------------------------------------------
  fcpd_head_if hif ();
  assign hif.xfer_req = busy_q && !seek_q;
  assign hif.xfer_done = busy_q && exec_end;
  assign hif.settle_steps = hst_q;
  assign hif.release_steps = hrt_q;
  assign xfer_go = hif.head_ready && busy_q && !seek_q; // [RQ8]
  assign head_loaded = hif.head_loaded;

  fcpd_head_timer u_timer (
    .mclk(mclk),
    .rst_n(rst_n),
    .hif(hif)
  );

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_queue_polarity: assert property (@(posedge mclk) disable iff (!rst_n) // [RQ2]
    cfg_load |=> queue_enable == !$past(cfg_queue_disable_bit))
    else $error("queue enable polarity wrong");
  a_lock_holds: assert property (@(posedge mclk) disable iff (!rst_n) // [RQ10]
    soft_reset && lock_q && !cfg_load
    |=> $stable(qdis_q) && $stable(qthr_q) && $stable(precomp_start_cylinder_q))
    else $error("locked settings changed");
  a_soft_clears: assert property (@(posedge mclk) disable iff (!rst_n) // [RQ10]
    soft_reset && !lock_q && !cfg_load |=> qdis_q && qthr_q == 4'h0 && precomp_start_cylinder_q == 8'h00)
    else $error("soft reset did not restore");
  a_param_hold: assert property (@(posedge mclk) disable iff (!rst_n) // [RQ18]
    busy_q && $past(busy_q) |-> $stable(cmd_q))
    else $error("parameter changed in execution");
  a_no_seek: assert property (@(posedge mclk) disable iff (!rst_n) // [RQ3]
    cmd_start && !busy_q && !eis_q |=> !seek_req)
    else $error("implied seek while disabled");
  a_gap2_perp: assert property (@(posedge mclk) disable iff (!rst_n) // [RQ5]
    !perp_mode |-> gap2_len == gap2_default)
    else $error("gap2 altered outside perpendicular");
  a_head_switch: assert property (@(posedge mclk) disable iff (!rst_n) // [RQ13]
    busy_q && sector_done && last_sect && can_switch && !vfy_cnt_end
    |=> head_out && sector_num == 8'h01)
    else $error("no continue on head one");
  a_track_end: assert property (@(posedge mclk) disable iff (!rst_n) // [RQ4]
    busy_q && sector_done && last_sect && head_q |=> track_end)
    else $error("no end at last sector");
  a_size_calc: assert property (@(posedge mclk) disable iff (!rst_n) // [RQ15]
    cmd_q.size_code == 8'h02 |-> phys_sector_bytes == 15'h0200)
    else $error("sector size wrong");

endmodule : fcpd_param_decode

// ===== tb/fcpd_drive_model.sv
/* Drive-side model: answers a pending implied seek with one done pulse.
   Assumes the decoder's clock and synchronous active-low reset. */
`timescale 1ns/1ps
module fcpd_drive_model #(
  parameter int SEEK_CYC = 6
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic seek_req,
  output logic seek_done
);
  int cnt_q;
  // ------------------------------------------------------------
  // Seek timing
  // ------------------------------------------------------------
  // One-shot: a stuck request must not produce a train of done pulses
  always_ff @(posedge mclk) begin
    if (!rst_n || !seek_req) begin
      cnt_q <= 0;
      seek_done <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 1;
      seek_done <= (cnt_q == SEEK_CYC);
    end
  end
endmodule : fcpd_drive_model

// ===== tb/testbench.sv
/* Self-checking bench for the command parameter decoder.
   Assumes a 250 MHz clock and the drive model for seeks. */
`timescale 1ns/1ps
module testbench
  import fcpd_pkg::*;
;
  logic mclk, rst_n, soft_reset, cfg_load, cfg_queue_disable_bit;
  logic cfg_auto_seek_before_transfer, lock_load, lock_value, perp_mode, spec_load;
  logic [3:0] cfg_queue_threshold, queue_threshold;
  logic [7:0] cfg_precomp_start_cylinder, spec_head_settle_interval;
  logic [7:0] spec_head_release_interval, cmd_first_sector, precomp_start_cylinder;
  logic cmd_start, cmd_is_verify, cmd_has_cyl, cmd_verify_by_count_flag;
  logic sector_done, exec_end, seek_done, queue_enable, settings_retain, seek_req;
  logic xfer_go, mfm_mode, head_out, track_end, verify_count_mode, head_loaded;
  logic [7:0] sector_num, gap2_len, gap3_len, verify_sectors, gap2_default;
  logic [14:0] phys_sector_bytes, host_bytes;
  fcpd_cmd_s cmd_in, p;
  int fail_count, check_count, n;
  bit te;

  fcpd_param_decode u_dut (.mclk, .rst_n, .soft_reset, .cfg_load, .cfg_queue_disable_bit,
    .cfg_auto_seek_before_transfer, .cfg_queue_threshold, .cfg_precomp_start_cylinder,
    .lock_load, .lock_value, .perp_mode, .spec_load, .spec_head_settle_interval,
    .spec_head_release_interval, .cmd_start, .cmd_is_verify, .cmd_has_cyl,
    .cmd_verify_by_count_flag, .cmd_in, .cmd_first_sector, .sector_done, .exec_end,
    .seek_done, .queue_enable, .queue_threshold, .precomp_start_cylinder, .settings_retain,
    .seek_req, .xfer_go, .mfm_mode, .head_out, .sector_num, .track_end, .gap2_len,
    .gap3_len, .phys_sector_bytes, .host_bytes, .verify_sectors, .verify_count_mode,
    .head_loaded, .gap2_default);
  fcpd_drive_model u_drive (.mclk, .rst_n, .seek_req, .seek_done);

  // Clock, 4 ns period
  always #2 mclk = ~mclk;

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [14:0] got, input logic [14:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task test_done;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  task start_cmd(input fcpd_cmd_s c, input logic hc, input logic v);
    @(posedge mclk);
    cmd_in <= c; cmd_has_cyl <= hc; cmd_is_verify <= v; cmd_verify_by_count_flag <= v;
    cmd_start <= 1'b1;
    @(posedge mclk);
    cmd_start <= 1'b0;
    #1;
  endtask : start_cmd
  task cfg(input logic qd, input logic as, input logic [3:0] th, input logic [7:0] pc);
    @(posedge mclk);
    cfg_queue_disable_bit <= qd; cfg_auto_seek_before_transfer <= as;
    cfg_queue_threshold <= th; cfg_precomp_start_cylinder <= pc; cfg_load <= 1'b1;
    @(posedge mclk);
    cfg_load <= 1'b0;
    #1;
  endtask : cfg
  task soft_rst;
    @(posedge mclk); soft_reset <= 1'b1;
    @(posedge mclk); soft_reset <= 1'b0;
    #1;
  endtask : soft_rst
  task end_exec;
    @(posedge mclk); exec_end <= 1'b1;
    @(posedge mclk); exec_end <= 1'b0;
  endtask : end_exec
  // Track end is a single-cycle pulse, so it is watched for three edges
  task sect;
    te = 0;
    @(posedge mclk); sector_done <= 1'b1;
    @(posedge mclk); sector_done <= 1'b0;
    repeat (3) begin #1 te |= (track_end === 1'b1); @(posedge mclk); end
    #1;
  endtask : sect

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task t_config;
    chk(queue_enable, 0); chk(settings_retain, 0); chk(head_loaded, 0);
    cfg(0, 0, 4'h5, 8'h20);
    chk(queue_enable, 1); chk(queue_threshold, 4'h5);
    soft_rst;
    chk({queue_enable, queue_threshold, precomp_start_cylinder}, 0);
    @(posedge mclk); lock_load <= 1'b1; lock_value <= 1'b1;
    @(posedge mclk); lock_load <= 1'b0;
    #1 chk(settings_retain, 1);
    cfg(0, 0, 4'h9, 8'h4c);
    soft_rst;
    chk({queue_enable, queue_threshold, precomp_start_cylinder}, 15'h194c);
    cfg(1, 0, 4'h9, 8'h4c);
    chk(queue_enable, 0);
    $display("test config done");
  endtask : t_config
  task t_sizes;
    chk(gap2_default, 8'h16);
    for (int c = 0; c < 8; c++) begin
      p = '0;
      p.size_code = 8'(c); // codes kept within 07
      p.mfm_sel = c[0]; p.head_side_select = c[1]; p.short_sector_byte_count = 8'h40;
      p.intersector_spacing_length = 8'(8'h1b + c); p.id_data_spacing = 8'(8'h30 + c);
      @(posedge mclk); perp_mode <= c[0];
      start_cmd(p, 0, 0);
      chk(phys_sector_bytes, 15'h80 << c);
      chk(host_bytes, c == 0 ? 15'h40 : 15'h80 << c);
      chk(mfm_mode, c[0]); chk(head_out, c[1]);
      chk(gap3_len, 8'h1b + c); chk(gap2_len, c[0] ? 8'h30 + c : 8'h16);
      end_exec;
    end
    $display("test sizes done");
  endtask : t_sizes
  // Joined track over both heads, with a refused start in mid-run
  task t_track;
    p = '0; p.two_side_track_join = 1'b1; p.last_sector_of_track = 8'h02;
    p.intersector_spacing_length = 8'h2a;
    @(posedge mclk); cmd_first_sector <= 8'h01;
    start_cmd(p, 0, 0);
    sect; chk({te, head_out, sector_num}, 15'h002);
    sect; chk({te, head_out, sector_num}, 15'h101);
    p.intersector_spacing_length = 8'h77; p.head_side_select = 1'b0;
    start_cmd(p, 0, 0);
    chk({gap3_len, head_out, sector_num}, 15'h5501);
    sect; chk({te, head_out, sector_num}, 15'h102);
    sect; chk(te, 1);
    end_exec;
    p = '0; p.last_sector_of_track = 8'h09; p.short_sector_byte_count = 8'h03;
    start_cmd(p, 0, 1);
    chk({verify_count_mode, verify_sectors}, 15'h103);
    sect; sect; chk(te, 0);
    sect; chk(te, 1);
    end_exec;
    $display("test track done");
  endtask : t_track
  task t_head;
    @(posedge mclk); spec_load <= 1'b1; spec_head_settle_interval <= 8'h00;
    spec_head_release_interval <= 8'h00;
    @(posedge mclk); spec_load <= 1'b0;
    // Earlier short commands leave the head timing; let it unload first
    n = 0;
    while (head_loaded !== 1'b0 && n < 1500) begin @(posedge mclk); #1 n++; end
    chk(head_loaded, 0);
    cfg(1, 1, 4'h0, 8'h00);
    start_cmd(p, 1, 0);
    chk(seek_req, 1);
    n = 0;
    while (head_loaded !== 1'b1 && n < 50) begin @(posedge mclk); #1 n++; end
    chk(head_loaded, 1); chk(xfer_go, 0);
    n = 0;
    while (xfer_go !== 1'b1 && n < 400) begin @(posedge mclk); #1 n++; end
    chk(15'(n >= 245 && n <= 256), 1);
    end_exec;
    n = 0;
    while (head_loaded !== 1'b0 && n < 400) begin @(posedge mclk); #1 n++; end
    chk(15'(n >= 244 && n <= 256), 1);
    cfg(1, 0, 4'h0, 8'h00);
    start_cmd(p, 1, 0);
    chk(seek_req, 0);
    end_exec;
    $display("test head done");
  endtask : t_head

  // ------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    {mclk, rst_n, soft_reset, cfg_load, cfg_queue_disable_bit, lock_load, lock_value} = '0;
    {cfg_auto_seek_before_transfer, perp_mode, spec_load, cmd_start, cmd_is_verify} = '0;
    {cmd_has_cyl, cmd_verify_by_count_flag, sector_done, exec_end} = '0;
    {cfg_queue_threshold, cfg_precomp_start_cylinder, cmd_first_sector} = '0;
    {spec_head_settle_interval, spec_head_release_interval, cmd_in} = '0;
    fail_count = 0;
    check_count = 0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    #1;
    t_config; t_sizes; t_track; t_head;
    test_done;
  end
  // Tests need about 1300 cycles; 20000 means a hang
  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    test_done;
  end
endmodule : testbench
